// file: logic/tcc_top.sv
// Timer/counter unit with three timers and four capture/compare channels.
//
// How it works
// - Timers advance once per twelve clock periods.
// - Counter mode counts pin falls, one per machine cycle.
// - Modes: 13-bit, 16-bit, 8-bit auto-reload.
// - Mode 3 splits timer0; timer1 holds.
// - Gate pins enable timer zero and one.
// - Timer two: 16-bit, divide-by-two, gated input.
// - Four 16-bit channels on timer two, pins.
// - Reload register is low and high bytes.
// - Reload mode 0: overflow loads reload value.
// - Reload mode 1: trigger fall loads, flags.
// - Compare match drives output, raises request.
// - Compare mode 0: set on match, overflow clears.
// - Compare mode 1: software level, overflow ignored.
// - Capture mode 0: pin change latches timer two.
// - Capture mode 1: low-byte write latches timer.
// - Channels use port-one pins 0 to 3.
// - Timer two count pin, reload trigger pin.
// - Timer zero/one count and gate pins.
`timescale 1ns/1ps

module tcc_top (
    input  wire logic       mclk_in,              // Oscillator clock.
    input  wire logic       rstn_in,              // Sync reset, low.
    input  wire logic       ce_in,                // Clock enable.
    input  wire logic [4:0] addr_in,              // Register address.
    input  wire logic [7:0] wdata_in,             // Write data.
    input  wire logic       wr_in,                // Write strobe.
    input  wire logic       rd_in,                // Read strobe.
    output logic      [7:0] rdata_out,            // Read data.
    input  wire logic       timer0_count_in,      // Timer 0 count pin.
    input  wire logic       timer1_count_in,      // Timer 1 count pin.
    input  wire logic       timer2_count_in,      // Timer 2 count pin.
    input  wire logic       ext_irq0_gate_in,     // Timer 0 gate pin.
    input  wire logic       ext_irq1_gate_in,     // Timer 1 gate pin.
    input  wire logic       reload_trigger_in,    // Reload trigger pin.
    input  wire logic [3:0] capcmp_pin_in,        // Channel pin levels.
    output logic      [3:0] capcmp_pin_out,       // Compare levels.
    output logic      [3:0] capcmp_pin_oe_n_out,  // Pin drive, low.
    output logic      [7:0] irq_req_out           // Sticky requests.
);

    // ==========================================================
    // Helper functions.

    // One step of timer zero or one; returns overflow and value.
    function automatic logic [16:0] t01_step(
        input logic [1:0]  md,
        input logic [15:0] v
    );
        logic [12:0] n13;
        logic [16:0] r;
        n13 = {v[15:8], v[4:0]} + 13'h0001;
        case (md)
            tcc_pkg::TMODE_13: begin
                r = {(n13 == 13'h0000), n13[12:5], v[7:5], n13[4:0]};
            end
            tcc_pkg::TMODE_16: begin
                r = {(v == 16'hFFFF), v + 16'h0001};
            end
            tcc_pkg::TMODE_RLD: begin
                if (v[7:0] == 8'hFF) begin
                    r = {1'b1, v[15:8], v[15:8]};
                end else begin
                    r = {1'b0, v[15:8], v[7:0] + 8'h01};
                end
            end
            default: begin
                r = {(v[7:0] == 8'hFF), v[15:8], v[7:0] + 8'h01};
            end
        endcase
        return r;
    endfunction : t01_step

    // Address of a channel register byte; channel 0 is the reload.
    function automatic logic [4:0] cc_addr(
        input logic [1:0] ch,
        input logic       hi
    );
        logic [4:0] a;
        if (ch == 2'h0) begin
            a = hi ? tcc_pkg::A_RLDH : tcc_pkg::A_RLDL;
        end else begin
            a = tcc_pkg::A_CC1L + {2'h0, ch - 2'h1, hi};
        end
        return a;
    endfunction : cc_addr

    // ==========================================================
    // Pin synchronisers and filters.

    logic [9:0] pins;
    logic [9:0] s1_r;
    logic [9:0] s2_r;
    logic [9:0] s3_r;
    logic [9:0] flt_r;
    logic [9:0] fltd_r;
    logic [9:0] fall;
    logic [9:0] chg;

    // Gather the pins in one vector.
    assign pins = {capcmp_pin_in, reload_trigger_in,
                   ext_irq1_gate_in, ext_irq0_gate_in,
                   timer2_count_in,
                   timer1_count_in, timer0_count_in};

    // A filtered level follows only when stages two and three agree.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            s1_r   <= tcc_pkg::PIN_IDLE;
            s2_r   <= tcc_pkg::PIN_IDLE;
            s3_r   <= tcc_pkg::PIN_IDLE;
            flt_r  <= tcc_pkg::PIN_IDLE;
            fltd_r <= tcc_pkg::PIN_IDLE;
        end else if (ce_in) begin
            s1_r   <= pins;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            flt_r  <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
            fltd_r <= flt_r;
        end
    end

    assign fall = fltd_r & ~flt_r;
    assign chg  = fltd_r ^ flt_r;

    // ==========================================================
    // Machine cycle and count events.

    logic [3:0] mc_cnt_r;
    logic       tick;
    logic [2:0] pend_r;
    logic [2:0] cnt_evt;

    // Divide the clock by twelve.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            mc_cnt_r <= 4'h0;
        end else if (ce_in) begin
            if (tick) begin
                mc_cnt_r <= 4'h0;
            end else begin
                mc_cnt_r <= mc_cnt_r + 4'h1;
            end
        end
    end

    assign tick = (mc_cnt_r == tcc_pkg::MC_MAX);

    // A pin fall waits for the next machine cycle; a new fall wins.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pend_r <= 3'h0;
        end else if (ce_in) begin
            pend_r <= (pend_r & ~{3{tick}}) | fall[2:0];
        end
    end

    assign cnt_evt = pend_r & {3{tick}};

    // ==========================================================
    // Control registers.

    logic [7:0] tctl_r;
    logic [7:0] tmod_r;
    logic [7:0] t2ctl_r;
    logic [7:0] ccmode_r;
    logic [7:0] cmpcfg_r;

    // Plain control bytes written by software.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            tctl_r   <= tcc_pkg::RST_BYTE;
            tmod_r   <= tcc_pkg::RST_BYTE;
            t2ctl_r  <= tcc_pkg::RST_BYTE;
            ccmode_r <= tcc_pkg::RST_BYTE;
            cmpcfg_r <= tcc_pkg::RST_BYTE;
        end else if (ce_in && wr_in) begin
            if (addr_in == tcc_pkg::A_TCTL) begin
                tctl_r <= wdata_in;
            end else if (addr_in == tcc_pkg::A_TMOD) begin
                tmod_r <= wdata_in;
            end else if (addr_in == tcc_pkg::A_T2CTL) begin
                t2ctl_r <= wdata_in;
            end else if (addr_in == tcc_pkg::A_CCMODE) begin
                ccmode_r <= wdata_in;
            end else if (addr_in == tcc_pkg::A_CMPCFG) begin
                cmpcfg_r <= wdata_in;
            end
        end
    end

    // ==========================================================
    // Timers zero and one.

    logic [1:0]  md0;
    logic [1:0]  md1;
    logic [15:0] t0_r;
    logic [15:0] t1_r;
    logic [16:0] st0;
    logic [16:0] st1;
    logic        en0;
    logic        en1;
    logic        en0h;
    logic        split;

    assign md0   = tmod_r[tcc_pkg::TM0_LSB +: 2];
    assign md1   = tmod_r[tcc_pkg::TM1_LSB +: 2];
    assign split = (md0 == tcc_pkg::TMODE_SPL);
    assign st0   = t01_step(md0, t0_r);
    assign st1   = t01_step(md1, t1_r);

    // Run, gate and source select for each timer.
    assign en0 = tctl_r[tcc_pkg::T0_RUN]
               & (~tmod_r[tcc_pkg::TM0_LSB + tcc_pkg::TM_GATE]
                  | flt_r[tcc_pkg::P_GATE0])
               & (tmod_r[tcc_pkg::TM0_LSB + tcc_pkg::TM_CT]
                  ? cnt_evt[0] : tick);
    assign en1 = tctl_r[tcc_pkg::T1_RUN]
               & (~tmod_r[tcc_pkg::TM1_LSB + tcc_pkg::TM_GATE]
                  | flt_r[tcc_pkg::P_GATE1])
               & (tmod_r[tcc_pkg::TM1_LSB + tcc_pkg::TM_CT]
                  ? cnt_evt[1] : tick)
               & (md1 != tcc_pkg::TMODE_SPL);
    // In split mode the high byte of timer 0 is a timer on run 1.
    assign en0h = split & tctl_r[tcc_pkg::T1_RUN] & tick;

    // Timer zero; a software write wins over a count.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            t0_r <= tcc_pkg::RST_WORD;
        end else if (ce_in) begin
            if (wr_in && addr_in == tcc_pkg::A_T0L) begin
                t0_r[7:0] <= wdata_in;
            end else if (en0) begin
                t0_r[7:0] <= st0[7:0];
            end
            if (wr_in && addr_in == tcc_pkg::A_T0H) begin
                t0_r[15:8] <= wdata_in;
            end else if (en0 && !split) begin
                t0_r[15:8] <= st0[15:8];
            end else if (en0h) begin
                t0_r[15:8] <= t0_r[15:8] + 8'h01;
            end
        end
    end

    // Timer one.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            t1_r <= tcc_pkg::RST_WORD;
        end else if (ce_in) begin
            if (wr_in && addr_in == tcc_pkg::A_T1L) begin
                t1_r[7:0] <= wdata_in;
            end else if (en1) begin
                t1_r[7:0] <= st1[7:0];
            end
            if (wr_in && addr_in == tcc_pkg::A_T1H) begin
                t1_r[15:8] <= wdata_in;
            end else if (en1) begin
                t1_r[15:8] <= st1[15:8];
            end
        end
    end

    // ==========================================================
    // Timer two with reload.

    tcc_pkg::tcc_t2src_t src2;
    logic [15:0] t2_r;
    logic [15:0] cc_w [4];
    logic        tick2;
    logic        pdiv_r;
    logic        en2;
    logic        ovf2;
    logic        ext_rld;
    logic        upd_r;
    logic        ovfd_r;

    assign src2 = tcc_pkg::tcc_t2src_t'(t2ctl_r[1:0]);

    // Select the count source of timer two.
    always_comb begin
        case (src2)
            tcc_pkg::T2_TIMER: tick2 = tick;
            tcc_pkg::T2_GATED: tick2 = tick & flt_r[tcc_pkg::P_T2CNT];
            tcc_pkg::T2_COUNT: tick2 = cnt_evt[2];
            default:           tick2 = 1'b0;
        endcase
    end

    // Optional divide by two ahead of timer two.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pdiv_r <= 1'b0;
        end else if (ce_in && tick2) begin
            pdiv_r <= ~pdiv_r;
        end
    end

    assign en2 = tick2 & (~t2ctl_r[tcc_pkg::T2_PRE] | pdiv_r);
    assign ovf2 = en2 & (t2_r == 16'hFFFF);
    assign ext_rld = fall[tcc_pkg::P_RLD]
                   & t2ctl_r[tcc_pkg::T2_RLDEN]
                   & t2ctl_r[tcc_pkg::T2_RMODE];

    // Timer two count; writes first, then reload, then counting.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            t2_r <= tcc_pkg::RST_WORD;
        end else if (ce_in) begin
            if (wr_in && addr_in == tcc_pkg::A_T2L) begin
                t2_r[7:0] <= wdata_in;
            end else if (wr_in && addr_in == tcc_pkg::A_T2H) begin
                t2_r[15:8] <= wdata_in;
            end else if (ext_rld) begin
                t2_r <= cc_w[0];
            end else if (ovf2 && t2ctl_r[tcc_pkg::T2_RLDEN]) begin
                t2_r <= cc_w[0];
            end else if (en2) begin
                t2_r <= t2_r + 16'h0001;
            end
        end
    end

    // Mark a cycle in which the new count may be compared.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            upd_r  <= 1'b0;
            ovfd_r <= 1'b0;
        end else if (ce_in) begin
            upd_r  <= en2 | ext_rld;
            ovfd_r <= ovf2;
        end
    end

    // ==========================================================
    // Capture/compare channels.

    logic [3:0] evt;
    logic [3:0] cmp_lvl;

    for (genvar g = 0; g < 4; g++) begin : g_ch
        logic [15:0] cc_r;
        logic        lvl_r;
        logic [1:0]  ccm;
        logic        wlo;
        logic        whi;
        logic        cap_pin;
        logic        match;

        assign ccm = ccmode_r[2*g +: 2];
        assign wlo = wr_in & (addr_in == cc_addr(2'(g), 1'b0));
        assign whi = wr_in & (addr_in == cc_addr(2'(g), 1'b1));
        assign cap_pin = (ccm == tcc_pkg::CCM_CPIN)
                       & chg[tcc_pkg::P_CC + g];
        assign match = (ccm == tcc_pkg::CCM_CMP) & upd_r
                     & (t2_r == cc_r);

        // Channel register: pin capture, write capture or plain write.
        always_ff @(posedge mclk_in) begin
            if (!rstn_in) begin
                cc_r <= tcc_pkg::RST_WORD;
            end else if (ce_in) begin
                if (cap_pin) begin
                    cc_r <= t2_r;
                end else if (wlo) begin
                    if (ccm == tcc_pkg::CCM_CWR) begin
                        cc_r <= t2_r;
                    end else begin
                        cc_r[7:0] <= wdata_in;
                    end
                end else if (whi) begin
                    cc_r[15:8] <= wdata_in;
                end
            end
        end

        // Compare output level for the two compare modes.
        always_ff @(posedge mclk_in) begin
            if (!rstn_in) begin
                lvl_r <= 1'b0;
            end else if (ce_in) begin
                if (!cmpcfg_r[g]) begin
                    if (match) begin
                        lvl_r <= 1'b1;
                    end else if (ovfd_r) begin
                        lvl_r <= 1'b0;
                    end
                end else if (match) begin
                    lvl_r <= cmpcfg_r[tcc_pkg::CFG_LVL + g];
                end
            end
        end

        assign cc_w[g]    = cc_r;
        assign cmp_lvl[g] = lvl_r;
        assign evt[g]     = cap_pin | match
                          | (wlo & (ccm == tcc_pkg::CCM_CWR));
        // Drive the pin only while the channel compares.
        assign capcmp_pin_oe_n_out[g] =
            (ccm != tcc_pkg::CCM_CMP);
    end

    assign capcmp_pin_out = cmp_lvl;

    // ==========================================================
    // Sticky event flags; a set wins over a write-one clear.

    logic [7:0] flag_r;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;

    assign flag_set = {evt,
                       ext_rld,
                       ovf2,
                       split ? (en0h & (t0_r[15:8] == 8'hFF))
                             : (en1 & st1[16]),
                       en0 & st0[16]};
    assign flag_clr = (wr_in && addr_in == tcc_pkg::A_FLAG)
                    ? wdata_in : 8'h00;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            flag_r <= tcc_pkg::RST_BYTE;
        end else if (ce_in) begin
            flag_r <= (flag_r & ~flag_clr) | flag_set;
        end
    end

    assign irq_req_out = flag_r;

    // ==========================================================
    // Read port; data stand one cycle after the strobe.

    logic [7:0] rd_nxt;
    logic [7:0] rdata_r;

    always_comb begin
        rd_nxt = 8'h00;
        if (addr_in == tcc_pkg::A_TCTL) begin
            rd_nxt = tctl_r;
        end else if (addr_in == tcc_pkg::A_TMOD) begin
            rd_nxt = tmod_r;
        end else if (addr_in == tcc_pkg::A_T0L) begin
            rd_nxt = t0_r[7:0];
        end else if (addr_in == tcc_pkg::A_T0H) begin
            rd_nxt = t0_r[15:8];
        end else if (addr_in == tcc_pkg::A_T1L) begin
            rd_nxt = t1_r[7:0];
        end else if (addr_in == tcc_pkg::A_T1H) begin
            rd_nxt = t1_r[15:8];
        end else if (addr_in == tcc_pkg::A_T2CTL) begin
            rd_nxt = t2ctl_r;
        end else if (addr_in == tcc_pkg::A_T2L) begin
            rd_nxt = t2_r[7:0];
        end else if (addr_in == tcc_pkg::A_T2H) begin
            rd_nxt = t2_r[15:8];
        end else if (addr_in == tcc_pkg::A_CCMODE) begin
            rd_nxt = ccmode_r;
        end else if (addr_in == tcc_pkg::A_CMPCFG) begin
            rd_nxt = cmpcfg_r;
        end else if (addr_in == tcc_pkg::A_FLAG) begin
            rd_nxt = flag_r;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (addr_in == cc_addr(2'(i), 1'b0)) begin
                    rd_nxt = cc_w[i][7:0];
                end else if (addr_in == cc_addr(2'(i), 1'b1)) begin
                    rd_nxt = cc_w[i][15:8];
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            rdata_r <= tcc_pkg::RST_BYTE;
        end else if (ce_in) begin
            rdata_r <= rd_in ? rd_nxt : 8'h00;
        end
    end

    assign rdata_out = rdata_r;

endmodule : tcc_top

// file: logic/tcc_pkg.sv
// Constants, register map and types of the timer/capture/compare unit.
package tcc_pkg;

    // ==========================================================
    // Register offsets on the byte-wide register port.
    localparam logic [4:0] A_TCTL   = 5'h00;
    localparam logic [4:0] A_TMOD   = 5'h01;
    localparam logic [4:0] A_T0L    = 5'h02;
    localparam logic [4:0] A_T0H    = 5'h03;
    localparam logic [4:0] A_T1L    = 5'h04;
    localparam logic [4:0] A_T1H    = 5'h05;
    localparam logic [4:0] A_T2CTL  = 5'h06;
    localparam logic [4:0] A_RLDL   = 5'h07;
    localparam logic [4:0] A_RLDH   = 5'h08;
    localparam logic [4:0] A_T2L    = 5'h09;
    localparam logic [4:0] A_T2H    = 5'h0A;
    localparam logic [4:0] A_CCMODE = 5'h0B;
    localparam logic [4:0] A_CMPCFG = 5'h0C;
    localparam logic [4:0] A_CC1L   = 5'h0D;
    localparam logic [4:0] A_FLAG   = 5'h13;

    // ==========================================================
    // Field positions.
    localparam int T0_RUN    = 0;
    localparam int T1_RUN    = 1;
    localparam int TM0_LSB   = 0;
    localparam int TM1_LSB   = 4;
    localparam int TM_CT     = 2;
    localparam int TM_GATE   = 3;
    localparam int T2_PRE    = 2;
    localparam int T2_RMODE  = 3;
    localparam int T2_RLDEN  = 4;
    localparam int CFG_LVL   = 4;
    localparam int FLG_T0    = 0;
    localparam int FLG_T1    = 1;
    localparam int FLG_T2    = 2;
    localparam int FLG_RLD   = 3;
    localparam int FLG_CC    = 4;
    // Pin vector positions.
    localparam int P_T0CNT   = 0;
    localparam int P_T1CNT   = 1;
    localparam int P_T2CNT   = 2;
    localparam int P_GATE0   = 3;
    localparam int P_GATE1   = 4;
    localparam int P_RLD     = 5;
    localparam int P_CC      = 6;
    localparam int NPIN      = 10;

    // ==========================================================
    // Reset values, counts and codes.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [9:0]  PIN_IDLE = 10'h3FF;
    localparam logic [3:0]  MC_MAX   = 4'hB;
    localparam logic [1:0]  TMODE_13  = 2'h0;
    localparam logic [1:0]  TMODE_16  = 2'h1;
    localparam logic [1:0]  TMODE_RLD = 2'h2;
    localparam logic [1:0]  TMODE_SPL = 2'h3;
    localparam logic [1:0]  CCM_OFF   = 2'h0;
    localparam logic [1:0]  CCM_CMP   = 2'h1;
    localparam logic [1:0]  CCM_CPIN  = 2'h2;
    localparam logic [1:0]  CCM_CWR   = 2'h3;

    // Timer two count source.
    typedef enum logic [1:0] {
        T2_STOP,
        T2_TIMER,
        T2_GATED,
        T2_COUNT
    } tcc_t2src_t;

endpackage : tcc_pkg

// file: verif/tcc_sva.sv
// Checker on the unit's ports.
`timescale 1ns/1ps

module tcc_sva (
    input wire logic       mclk_in,             // Clock.
    input wire logic       rstn_in,             // Reset, low.
    input wire logic [4:0] addr_in,             // Address.
    input wire logic [7:0] wdata_in,            // Write data.
    input wire logic       wr_in,               // Write strobe.
    input wire logic       rd_in,               // Read strobe.
    input wire logic [7:0] rdata_out,           // Read data.
    input wire logic       reload_trigger_in,   // Trigger pin.
    input wire logic [3:0] capcmp_pin_out,      // Compare levels.
    input wire logic [3:0] capcmp_pin_oe_n_out, // Drive, low.
    input wire logic [7:0] irq_req_out          // Requests.
);
    logic [7:0] clr_r;   // Last clear mask.
    logic [3:0] since_r; // Age of trigger fall.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    // ==========================================================
    // Clear mask and trigger age.
    always_ff @(posedge mclk_in) begin
        clr_r <= (wr_in && addr_in == 5'h13) ? wdata_in : 8'h00;
    end
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            since_r <= 4'hF;
        end else if ($fell(reload_trigger_in)) begin
            since_r <= 4'h0;
        end else if (since_r != 4'hF) begin
            since_r <= since_r + 4'h1;
        end
    end
    sequence s_no_rd;
        !rd_in;
    endsequence
    sequence s_rd_hole;
        rd_in && addr_in > 5'h13;
    endsequence

    // ==========================================================
    // Assertions.
    chk_rd_idle: assert property (s_no_rd |=> rdata_out == 8'h00)
        else $error("rdata not zero");
    chk_rd_hole: assert property (s_rd_hole |=> rdata_out == 8'h00)
        else $error("hole not zero");
    chk_reset_state: assert property ($rose(rstn_in) |->
        irq_req_out == 8'h00 && capcmp_pin_out == 4'h0
        && capcmp_pin_oe_n_out == 4'hF) else $error("bad reset state");
    chk_flag_sticky: assert property (
        $past(rstn_in) |-> ($past(irq_req_out) & ~irq_req_out & ~clr_r)
        == 8'h00) else $error("flag lost");
    chk_cmp_request: assert property (
        (capcmp_pin_out & ~$past(capcmp_pin_out) & ~irq_req_out[7:4])
        == 4'h0) else $error("rise without flag");
    chk_cmp_drive: assert property (
        (capcmp_pin_out & ~$past(capcmp_pin_out) & capcmp_pin_oe_n_out)
        == 4'h0) else $error("rise on undriven pin");
    chk_cmp_fall: assert property (
        ($past(capcmp_pin_out) & ~capcmp_pin_out
        & ~({4{irq_req_out[2]}} | irq_req_out[7:4])) == 4'h0)
        else $error("fall without event");
    chk_rld_event: assert property (
        $rose(irq_req_out[3]) |-> since_r <= 4'h8)
        else $error("reload flag without fall");
endmodule : tcc_sva

bind tcc_top tcc_sva tcc_sva_inst (.*);

// file: verif/tcc_pins.sv
// Board pin model.
`timescale 1ns/1ps

module tcc_pins (
    input  wire logic       mclk_in,  // Clock.
    input  wire logic [3:0] lvl_in,   // Compare levels.
    input  wire logic [3:0] oe_n_in,  // Drive, low.
    output logic            cnt_out,  // Count pins.
    output logic            trig_out, // Reload trigger pin.
    output logic [3:0]      pin_out   // Channel pins.
);
    logic [3:0] ext_r = 4'hF; // 1 = released.

    // Pins idle high.
    initial begin
        cnt_out = 1'b1;
        trig_out = 1'b1;
    end
    // Device drive wins over the pull-up.
    assign pin_out = (oe_n_in & ext_r) | (~oe_n_in & lvl_in);

    // Falls 24 clocks apart.
    task automatic pulse_cnt(input int n);
        repeat (n) begin
            cnt_out <= 1'b0;
            repeat (12) @(posedge mclk_in);
            cnt_out <= 1'b1;
            repeat (12) @(posedge mclk_in);
        end
    endtask : pulse_cnt
    // One low pulse on the trigger pin.
    task automatic pulse_trig();
        trig_out <= 1'b0;
        repeat (12) @(posedge mclk_in);
        trig_out <= 1'b1;
        repeat (12) @(posedge mclk_in);
    endtask : pulse_trig
    // Sets channel board levels.
    task automatic set_ext(input logic [3:0] v);
        ext_r <= v;
        repeat (12) @(posedge mclk_in);
    endtask : set_ext
endmodule : tcc_pins

// file: verif/tcc_top_tb.sv
// Bench for the timer unit.
`timescale 1ns/1ps

module tcc_top_tb;
    logic       mclk_in  = 1'b0;
    logic       rstn_in  = 1'b0;
    logic [4:0] addr_in  = 5'h00;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in    = 1'b0;
    logic       rd_in    = 1'b0;
    logic       gate_r   = 1'b0;
    logic [7:0] rdata, irq;
    logic [3:0] lvl, oe_n, pins;
    logic       cnt, trig;
    int         n_mismatch = 0;
    int         checks_done = 0;

    // ==========================================================
    // Design and board.
    tcc_top tcc_top_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .ce_in(1'b1), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .timer0_count_in(cnt), .timer1_count_in(cnt),
        .timer2_count_in(cnt), .ext_irq0_gate_in(gate_r),
        .ext_irq1_gate_in(gate_r), .reload_trigger_in(trig),
        .capcmp_pin_in(pins), .capcmp_pin_out(lvl),
        .capcmp_pin_oe_n_out(oe_n), .irq_req_out(irq));
    tcc_pins tcc_pins_inst (.mclk_in(mclk_in), .lvl_in(lvl),
        .oe_n_in(oe_n), .cnt_out(cnt), .trig_out(trig), .pin_out(pins));

    // ==========================================================
    // Bus tasks and verdict.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask : wr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rc(input logic [4:0] a, input logic [7:0] exp);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge mclk_in);
    endtask : rc
    task automatic conclude();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Scenarios.
    task automatic s_modes();
        logic [7:0] tl [4] = '{8'h1E, 8'hFE, 8'hFE, 8'hFE};
        logic [7:0] th [4] = '{8'hFF, 8'hFF, 8'h80, 8'hFE};
        logic [7:0] el [4] = '{8'h01, 8'h01, 8'h81, 8'h01};
        logic [7:0] eh [4] = '{8'h00, 8'h00, 8'h80, 8'h01};
        for (int m = 0; m < 4; m++) begin
            wr(5'h01, {2'h0, m[1:0], 2'h0, m[1:0]});
            wr(5'h02, tl[m]);
            wr(5'h03, th[m]);
            wr(5'h04, 8'h05);
            wr(5'h05, 8'h00);
            wr(5'h00, 8'h03);
            repeat (34) @(posedge mclk_in);
            wr(5'h00, 8'h00);
            rc(5'h02, el[m]);
            rc(5'h03, eh[m]);
            rc(5'h13, (m == 3) ? 8'h03 : 8'h01);
            rc(5'h04, (m == 3) ? 8'h05 : 8'h08);
            wr(5'h13, 8'hFF);
        end
    endtask : s_modes
    task automatic s_count();
        wr(5'h01, 8'h0D);
        wr(5'h02, 8'h00);
        wr(5'h06, 8'h03);
        wr(5'h00, 8'h01);
        tcc_pins_inst.pulse_cnt(3);
        rc(5'h02, 8'h00);
        gate_r <= 1'b1;
        tcc_pins_inst.pulse_cnt(3);
        rc(5'h02, 8'h03);
        rc(5'h09, 8'h06);
    endtask : s_count
    task automatic s_reload();
        wr(5'h09, 8'hFE);
        wr(5'h0A, 8'hFF);
        wr(5'h07, 8'hF0);
        wr(5'h08, 8'hFF);
        wr(5'h0D, 8'hF8);
        wr(5'h0E, 8'hFF);
        wr(5'h0B, 8'h04);
        wr(5'h06, 8'h11);
        repeat (130) @(posedge mclk_in);
        #1 chk({4'h0, lvl}, 8'h02);
        chk({4'h0, oe_n}, 8'h0D);
        rc(5'h13, 8'h24);
        repeat (106) @(posedge mclk_in);
        #1 chk({4'h0, lvl}, 8'h00);
        wr(5'h0C, 8'h22);
        repeat (178) @(posedge mclk_in);
        #1 chk({4'h0, lvl}, 8'h02);
    endtask : s_reload
    task automatic s_trig_capture();
        wr(5'h07, 8'h34);
        wr(5'h08, 8'h12);
        wr(5'h06, 8'h18);
        wr(5'h13, 8'hFF);
        tcc_pins_inst.pulse_trig();
        rc(5'h09, 8'h34);
        rc(5'h0A, 8'h12);
        wr(5'h0B, 8'hE4);
        tcc_pins_inst.set_ext(4'hB);
        rc(5'h0F, 8'h34);
        rc(5'h10, 8'h12);
        rc(5'h13, 8'h48);
        wr(5'h09, 8'h56);
        wr(5'h11, 8'hAA);
        rc(5'h11, 8'h56);
        wr(5'h1F, 8'hA5);
        rc(5'h1F, 8'h00);
    endtask : s_trig_capture

    // ==========================================================
    // Clock, watchdog, main.
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (5000) @(posedge mclk_in);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        s_modes();
        s_count();
        s_reload();
        s_trig_capture();
        conclude();
    end
endmodule : tcc_top_tb
